// >>> logic/mhs_pkg.sv
// shared constants, register map and types of the host serial mode block
package mhs_pkg;
   // ------------------------------------------------------------
   // clocking and timing
   // ------------------------------------------------------------
   localparam int unsigned MHS_CLK_HZ        = 125000000;
   localparam int unsigned MHS_GUARD_UNIT_MS = 20;
   localparam int unsigned MHS_MS_PER_S      = 1000;
   localparam int          MHS_CW            = 20;
   localparam int unsigned MHS_RATES [8] = '{300, 1200, 2400, 9600,
                                             19200, 38400, 115200, 307200};

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int         MHS_AW         = 8;
   localparam logic [7:0] MHS_OFF_SERFMT = 8'h00;
   localparam logic [7:0] MHS_OFF_LINE   = 8'h04;
   localparam logic [7:0] MHS_OFF_PINFN  = 8'h08;
   localparam logic [7:0] MHS_OFF_ESCCHR = 8'h0c;
   localparam logic [7:0] MHS_OFF_GUARD  = 8'h10;
   localparam logic [7:0] MHS_OFF_PROTO  = 8'h14;
   localparam logic [7:0] MHS_OFF_CTRL   = 8'h18;
   localparam logic [7:0] MHS_OFF_STATUS = 8'h1c;

   localparam logic [2:0] MHS_RATE_RST   = 3'b010;
   localparam logic [7:0] MHS_ESC_RST    = 8'h2b;
   localparam logic [7:0] MHS_GUARD_RST  = 8'h32;
   localparam logic [7:0] MHS_GUARD_OFF  = 8'hff;
   localparam logic [1:0] MHS_PINFN_ESC  = 2'b11;
   localparam int         MHS_PINFN_LSB  = 4;
   localparam int         MHS_PROTO_SEC  = 0;
   localparam int         MHS_CTRL_CONN  = 0;
   localparam int         MHS_CTRL_CODE  = 1;
   localparam int         MHS_CTRL_ONL   = 3;

   // ------------------------------------------------------------
   // result characters
   // ------------------------------------------------------------
   localparam logic [7:0] MHS_CHR_C = 8'h63;
   localparam logic [7:0] MHS_CHR_D = 8'h64;
   localparam logic [7:0] MHS_CHR_V = 8'h76;
   localparam logic [7:0] MHS_CHR_N = 8'h4e;
   localparam logic [1:0] MHS_CODE_D = 2'b01;
   localparam logic [1:0] MHS_CODE_V = 2'b10;
   localparam logic [1:0] MHS_ESC_FULL = 2'd3;
   localparam logic [3:0] MHS_BITS8 = 4'd10;
   localparam logic [3:0] MHS_BITS9 = 4'd11;

   typedef struct packed {
      logic       nine;
      logic [2:0] rate;
   } mhs_serfmt_s;

   typedef struct packed {
      logic nine;
      logic ninth_bit_escape_enable;
   } mhs_linefmt_s;

   typedef enum logic {
      MHS_MODE_CMD  = 1'b0,
      MHS_MODE_DATA = 1'b1
   } mhs_mode_e;

   function automatic logic [MHS_CW-1:0] mhs_bit_cycles(input logic [2:0] code,
                                                       input int unsigned clk_hz);
      return MHS_CW'(clk_hz / MHS_RATES[code]);
   endfunction
endpackage

// >>> logic/mhs_rx.sv
// host-side asynchronous character receiver, mid-bit sampling
`timescale 1ns/1ps
`default_nettype none
module mhs_rx
   import mhs_pkg::*;
(
   input  wire logic              clk,      // device clock
   input  wire logic              rstn,     // async reset, active low
   input  wire logic              rxd,      // serial input from host
   input  wire logic [MHS_CW-1:0] bit_cyc,  // cycles per bit
   input  wire logic              nine,     // nine data bits
   output logic                   busy,     // frame in progress
   output logic [8:0]             data,     // received character
   output logic                   valid     // one-cycle strobe
);
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } mhs_rx_e;

   mhs_rx_e           state;
   logic [MHS_CW-1:0] cnt;
   logic [3:0]        idx;
   logic [8:0]        sh;
   wire               tick = (cnt == '0);
   wire  [3:0]        last = nine ? 4'd8 : 4'd7;

   assign busy = (state != RX_IDLE);

   // ------------------------------------------------------------
   // frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= RX_IDLE;
         cnt   <= '0;
         idx   <= '0;
         sh    <= '0;
         data  <= '0;
         valid <= 1'b0;
      end
      else
      begin
         valid <= 1'b0;
         cnt   <= tick ? bit_cyc - 1'b1 : cnt - 1'b1;
         unique case (state)
            RX_IDLE:
               if (!rxd)
               begin
                  state <= RX_START;
                  cnt   <= bit_cyc >> 1;
               end
            // recheck at centre; a glitch is dropped
            RX_START:
               if (tick)
               begin
                  state <= rxd ? RX_IDLE : RX_DATA;
                  idx   <= '0;
               end
            RX_DATA:
               if (tick)
               begin
                  sh  <= {rxd, sh[8:1]};
                  idx <= idx + 1'b1;
                  if (idx == last)
                     state <= RX_STOP;
               end
            // stop level is not checked, only its centre is awaited
            RX_STOP:
               if (tick)
               begin
                  state <= RX_IDLE;
                  valid <= 1'b1;
                  data  <= nine ? sh : {1'b0, sh[8:1]};
               end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> logic/mhs_serial_mode_ctrl.sv
// host serial port with command/data mode control and escape detection
`timescale 1ns/1ps
`default_nettype none
module mhs_serial_mode_ctrl #(
   parameter int unsigned CLK_HZ         = mhs_pkg::MHS_CLK_HZ,
   parameter int unsigned GUARD_UNIT_CYC = CLK_HZ / mhs_pkg::MHS_MS_PER_S
                                           * mhs_pkg::MHS_GUARD_UNIT_MS
)(
   input  wire logic                      pclk,               // clock
   input  wire logic                      presetn,            // async reset
   input  wire logic                      psel,               // apb select
   input  wire logic                      penable,            // apb enable
   input  wire logic                      pwrite,             // apb write
   input  wire logic [mhs_pkg::MHS_AW-1:0] paddr,             // apb address
   input  wire logic [31:0]               pwdata,             // apb write data
   output logic      [31:0]               prdata,             // apb read data
   output logic                           pready,             // apb ready
   output logic                           pslverr,            // apb error
   input  wire logic                      host_txd,           // serial from host
   output logic                           host_rxd,           // serial to host
   output logic                           clear_to_send_n,    // flow control
   input  wire logic                      escape_capable_pin, // escape pin
   input  wire logic                      line_carrier,       // carrier present
   output logic      [8:0]                line_tx_data,       // payload to line
   output logic                           line_tx_valid,      // payload valid
   input  wire logic                      line_tx_ready,      // line accepts
   input  wire logic [8:0]                line_rx_data,       // line to host
   input  wire logic                      line_rx_valid,      // line data valid
   output logic                           line_rx_ready,      // block accepts
   output logic      [8:0]                cmd_data,           // command char
   output logic                           cmd_valid,          // command strobe
   output logic                           data_mode           // in data mode
);
   import mhs_pkg::*;

   localparam int GW = $clog2(GUARD_UNIT_CYC + 1);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   mhs_serfmt_s  serfmt;
   mhs_linefmt_s linefmt;
   logic [1:0]   pin_fn;
   logic [7:0]   esc_chr;
   logic [7:0]   guard;
   logic [7:0]   proto;

   wire wr_en   = psel & penable & pwrite;
   wire sel_ser = (paddr == MHS_OFF_SERFMT);
   wire sel_lin = (paddr == MHS_OFF_LINE);
   wire sel_pin = (paddr == MHS_OFF_PINFN);
   wire sel_esc = (paddr == MHS_OFF_ESCCHR);
   wire sel_grd = (paddr == MHS_OFF_GUARD);
   wire sel_pro = (paddr == MHS_OFF_PROTO);
   wire sel_ctl = (paddr == MHS_OFF_CTRL);
   wire sel_sta = (paddr == MHS_OFF_STATUS);
   wire mapped  = sel_ser | sel_lin | sel_pin | sel_esc | sel_grd
                | sel_pro | sel_ctl | sel_sta;

   wire conn_req   = wr_en & sel_ctl & pwdata[MHS_CTRL_CONN];
   wire online_req = wr_en & sel_ctl & pwdata[MHS_CTRL_ONL];
   wire [1:0] code = pwdata[MHS_CTRL_CODE +: 2];

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serfmt  <= '{nine: 1'b0, rate: MHS_RATE_RST};
         linefmt <= '0;
         pin_fn  <= '0;
         esc_chr <= MHS_ESC_RST;
         guard   <= MHS_GUARD_RST;
         proto   <= '0;
      end
      else if (wr_en)
      begin
         if (sel_ser)
            serfmt <= mhs_serfmt_s'(pwdata[3:0]);
         if (sel_lin)
            linefmt <= mhs_linefmt_s'(pwdata[1:0]);
         if (sel_pin)
            pin_fn <= pwdata[MHS_PINFN_LSB +: 2];
         if (sel_esc)
            esc_chr <= pwdata[7:0];
         if (sel_grd)
            guard <= pwdata[7:0];
         if (sel_pro)
            proto <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // receiver and state
   // ------------------------------------------------------------
   mhs_mode_e   mode;
   mhs_mode_e   next_mode;
   logic        rx_busy;
   logic        rx_busy_q;
   logic [8:0]  rx_data;
   logic        rx_valid;
   logic        tx_busy;
   logic [10:0] tx_sr;
   logic [3:0]  tx_left;
   logic [MHS_CW-1:0] tx_cnt;
   logic        res_pend;
   logic [7:0]  res_chr;
   logic [1:0]  esc_cnt;
   logic [1:0]  next_esc_cnt;
   logic [GW-1:0] unit_cnt;
   logic [7:0]  idle_units;
   logic        pre_quiet;
   logic        pin_q;
   logic        car_q;

   wire [MHS_CW-1:0] bit_cyc = mhs_bit_cycles(serfmt.rate, CLK_HZ);
   wire is_data  = (mode == MHS_MODE_DATA);
   wire rx_start = rx_busy & ~rx_busy_q;

   mhs_rx u_rx (
      .clk     (pclk),
      .rstn    (presetn),
      .rxd     (host_txd),
      .bit_cyc (bit_cyc),
      .nine    (serfmt.nine),
      .busy    (rx_busy),
      .data    (rx_data),
      .valid   (rx_valid)
   );

   // ------------------------------------------------------------
   // escape detection
   // ------------------------------------------------------------
   // ninth-bit escape
   wire nb_esc = rx_valid & is_data & serfmt.nine & linefmt.ninth_bit_escape_enable
               & ~proto[MHS_PROTO_SEC] & rx_data[8];
   wire pin_esc = is_data & (pin_fn == MHS_PINFN_ESC)
                & escape_capable_pin & ~pin_q;
   wire car_lost = is_data & car_q & ~line_carrier;

   // guard silence measured in units; a zero guard is always met
   wire unit_tick = (unit_cnt == GW'(GUARD_UNIT_CYC - 1));
   wire quiet     = (idle_units >= guard);
   wire seq_en    = is_data & (guard != MHS_GUARD_OFF);
   wire plus_done = (esc_cnt == MHS_ESC_FULL) & quiet & ~rx_busy;
   wire is_esc    = (rx_data[7:0] == esc_chr);
   wire escape    = nb_esc | pin_esc | plus_done | car_lost;

   always_comb
   begin
      next_esc_cnt = esc_cnt;
      if (!seq_en || plus_done)
         next_esc_cnt = '0;
      else if (rx_valid)
      begin
         // first char needs silence before it
         if (is_esc && esc_cnt != MHS_ESC_FULL && (esc_cnt != '0 || pre_quiet))
            next_esc_cnt = esc_cnt + 1'b1;
         else
            next_esc_cnt = '0;
      end
      else if (rx_start && esc_cnt == MHS_ESC_FULL)
         next_esc_cnt = '0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit_cnt   <= '0;
         idle_units <= '0;
         pre_quiet  <= 1'b0;
         esc_cnt    <= '0;
         rx_busy_q  <= 1'b0;
         pin_q      <= 1'b0;
         car_q      <= 1'b0;
      end
      else
      begin
         rx_busy_q <= rx_busy;
         pin_q     <= escape_capable_pin;
         car_q     <= line_carrier;
         esc_cnt   <= next_esc_cnt;
         unit_cnt  <= (rx_busy | unit_tick) ? '0 : unit_cnt + 1'b1;
         if (rx_busy)
            idle_units <= '0;
         else if (unit_tick && idle_units != MHS_GUARD_OFF)
            idle_units <= idle_units + 1'b1;
         if (rx_start)
            pre_quiet <= quiet;
      end
   end

   // ------------------------------------------------------------
   // mode control
   // ------------------------------------------------------------
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         MHS_MODE_CMD:
            if (conn_req || online_req)
               next_mode = MHS_MODE_DATA;
         MHS_MODE_DATA:
            if (escape)
               next_mode = MHS_MODE_CMD;
      endcase
   end

   wire res_take = ~tx_busy & res_pend;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode     <= MHS_MODE_CMD;
         res_pend <= 1'b0;
         res_chr  <= '0;
      end
      else
      begin
         mode <= next_mode;
         if (res_take)
            res_pend <= 1'b0;
         if (car_lost)
         begin
            res_pend <= 1'b1;
            res_chr  <= MHS_CHR_N;
         end
         else if (conn_req && !is_data)
         begin
            res_pend <= 1'b1;
            res_chr  <= (code == MHS_CODE_D) ? MHS_CHR_D
                      : (code == MHS_CODE_V) ? MHS_CHR_V : MHS_CHR_C;
         end
      end
   end

   // ------------------------------------------------------------
   // host character routing
   // ------------------------------------------------------------
   // drop msb; zero msb when line is wider
   wire [8:0] to_line = {serfmt.nine & linefmt.nine & rx_data[8], rx_data[7:0]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_valid     <= 1'b0;
         cmd_data      <= '0;
         line_tx_valid <= 1'b0;
         line_tx_data  <= '0;
      end
      else
      begin
         cmd_valid <= rx_valid & ~is_data;
         if (rx_valid && !is_data)
            cmd_data <= rx_data;
         if (line_tx_ready)
            line_tx_valid <= 1'b0;
         if (rx_valid && is_data && !nb_esc)
         begin
            line_tx_valid <= 1'b1;
            line_tx_data  <= to_line;
         end
      end
   end

   // held off while receiving or holding a char
   assign clear_to_send_n = rx_busy | line_tx_valid;
   assign data_mode       = is_data;

   // ------------------------------------------------------------
   // transmitter to host
   // ------------------------------------------------------------
   assign line_rx_ready = ~tx_busy & ~res_pend & is_data;
   wire       tx_load = res_take | (line_rx_ready & line_rx_valid);
   wire [8:0] tx_chr  = res_pend ? {1'b0, res_chr}
                      : {line_rx_data[8] & linefmt.nine, line_rx_data[7:0]};
   // start low, lsb first, stop high
   wire [10:0] frame  = serfmt.nine ? {1'b1, tx_chr, 1'b0}
                      : {2'b11, tx_chr[7:0], 1'b0};

   assign host_rxd = tx_sr[0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_busy <= 1'b0;
         tx_sr   <= '1;
         tx_left <= '0;
         tx_cnt  <= '0;
      end
      else if (tx_load)
      begin
         tx_busy <= 1'b1;
         tx_sr   <= frame;
         tx_left <= serfmt.nine ? MHS_BITS9 : MHS_BITS8;
         tx_cnt  <= bit_cyc - 1'b1;
      end
      else if (tx_busy)
      begin
         tx_cnt <= (tx_cnt == '0) ? bit_cyc - 1'b1 : tx_cnt - 1'b1;
         if (tx_cnt == '0)
         begin
            tx_sr   <= {1'b1, tx_sr[10:1]};
            tx_left <= tx_left - 1'b1;
            tx_busy <= (tx_left != 4'd1);
         end
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   wire [31:0] status = {24'h0, line_carrier, res_pend, esc_cnt, tx_busy,
                         rx_busy, ~clear_to_send_n, is_data};
   wire [31:0] rd_val = sel_ser ? {28'h0, serfmt}
                      : sel_lin ? {30'h0, linefmt}
                      : sel_pin ? {26'h0, pin_fn, 4'h0}
                      : sel_esc ? {24'h0, esc_chr}
                      : sel_grd ? {24'h0, guard}
                      : sel_pro ? {24'h0, proto}
                      : sel_sta ? status : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= rd_val;
   end
endmodule
`default_nettype wire

// >>> bench/mhs_checker.sv
// port-level assertions for the host serial mode block
`timescale 1ns/1ps
`default_nettype none
module mhs_checker
   import mhs_pkg::*;
#(
   parameter int unsigned CLK_HZ         = MHS_CLK_HZ,
   parameter int unsigned GUARD_UNIT_CYC = CLK_HZ / MHS_MS_PER_S * MHS_GUARD_UNIT_MS
)(
   input wire logic              pclk,               // clock
   input wire logic              presetn,            // async reset
   input wire logic              psel,               // apb select
   input wire logic              penable,            // apb enable
   input wire logic              pwrite,             // apb write
   input wire logic [MHS_AW-1:0] paddr,              // apb address
   input wire logic [31:0]       pwdata,             // apb write data
   input wire logic              pslverr,            // apb error
   input wire logic              host_txd,           // serial from host
   input wire logic              clear_to_send_n,    // flow control
   input wire logic              escape_capable_pin, // escape pin
   input wire logic              line_carrier,       // carrier
   input wire logic [8:0]        line_tx_data,       // payload
   input wire logic              line_tx_valid,      // payload valid
   input wire logic              line_tx_ready,      // line accepts
   input wire logic              cmd_valid,          // command strobe
   input wire logic              data_mode           // mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic pin_esc;
   wire  wr      = psel && penable && pwrite;
   wire  ctrl_wr = wr && paddr == MHS_OFF_CTRL;
   wire  mapped  = paddr <= MHS_OFF_STATUS && paddr[1:0] == 2'b00;
   // pin function is only visible through the bus writes
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pin_esc <= 1'b0;
      else if (wr && paddr == MHS_OFF_PINFN)
         pin_esc <= pwdata[MHS_PINFN_LSB+:2] == MHS_PINFN_ESC;
   reset_cmd_mode_a:
      assert property (!$past(presetn) |-> !data_mode && !cmd_valid) else $error("mode at reset");
   apb_err_a:
      assert property (pslverr == (psel && penable && !mapped)) else $error("pslverr wrong");
   connect_data_a:
      assert property (ctrl_wr && pwdata[MHS_CTRL_CONN] && !data_mode |=> data_mode)
      else $error("connect ignored");
   online_data_a:
      assert property (ctrl_wr && pwdata[MHS_CTRL_ONL] |=> data_mode) else $error("online ignored");
   no_cmd_data_a:
      assert property (data_mode && $past(data_mode) && $past(data_mode, 2) |-> !cmd_valid)
      else $error("command char in data mode");
   payload_hold_a:
      assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data))
      else $error("payload dropped");
   pin_escape_a:
      assert property (data_mode && pin_esc && $rose(escape_capable_pin) |-> ##[1:3] !data_mode)
      else $error("pin escape missed");
   carrier_loss_a:
      assert property (data_mode && $fell(line_carrier) |-> ##[1:3] !data_mode)
      else $error("carrier loss missed");
   cts_start_a:
      assert property ($fell(host_txd) && !clear_to_send_n |-> ##[1:3] clear_to_send_n)
      else $error("cts not negated");
endmodule
bind mhs_serial_mode_ctrl mhs_checker #(.CLK_HZ(CLK_HZ), .GUARD_UNIT_CYC(GUARD_UNIT_CYC)) CHK (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .host_txd,
   .clear_to_send_n, .escape_capable_pin, .line_carrier, .line_tx_data, .line_tx_valid,
   .line_tx_ready, .cmd_valid, .data_mode);
`default_nettype wire

// >>> bench/mhs_host_model.sv
// host uart model: sends characters and collects replies
`timescale 1ns/1ps
`default_nettype none
module mhs_host_model (
   input  wire logic pclk, // clock
   output logic      txd,  // serial to device
   input  wire logic rxd   // serial from device
);
   int         bc = 520;
   int         nb = 8;
   logic [8:0] rxq[$];
   initial txd = 1'b1;
   // start low, lsb first, stop high
   task automatic send(input logic [8:0] ch);
      txd <= 1'b0;
      repeat (bc) @(posedge pclk);
      for (int i = 0; i < nb; i++)
      begin
         txd <= ch[i];
         repeat (bc) @(posedge pclk);
      end
      txd <= 1'b1;
      repeat (bc) @(posedge pclk);
   endtask
   // mid-bit sampling; stop bit not checked
   always
   begin : rx
      logic [8:0] v;
      @(negedge rxd);
      v = '0;
      repeat (bc / 2) @(posedge pclk);
      for (int i = 0; i < nb; i++)
      begin
         repeat (bc) @(posedge pclk);
         v[i] = rxd;
      end
      repeat (bc) @(posedge pclk);
      rxq.push_back(v);
   end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the host serial mode block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mhs_pkg::*;
   localparam int unsigned CLK_HZ = 1250000;
   logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, host_txd, host_rxd;
   logic clear_to_send_n, escape_capable_pin, line_carrier, line_tx_valid, line_tx_ready;
   logic line_rx_valid, line_rx_ready, cmd_valid, data_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [8:0] line_tx_data, line_rx_data, cmd_data;
   int errors = 0, check_count = 0, hn = 0, ln = 0, seed = 32'ha5222cf1;
   int exp_line[$], exp_cmd[$];
   always #4 pclk = ~pclk;
   mhs_serial_mode_ctrl #(.CLK_HZ(CLK_HZ), .GUARD_UNIT_CYC(16)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .host_txd, .host_rxd, .clear_to_send_n, .escape_capable_pin, .line_carrier,
      .line_tx_data, .line_tx_valid, .line_tx_ready, .line_rx_data, .line_rx_valid,
      .line_rx_ready, .cmd_data, .cmd_valid, .data_mode);
   mhs_host_model HM (.pclk, .txd(host_txd), .rxd(host_rxd));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("reg %h", a), x, r);
   endtask
   task automatic mode_is(input logic e);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("data_mode", e, data_mode);
      @(posedge pclk);
   endtask
   task automatic get_rx(input logic [8:0] e);
      for (int i = 0; i < 3000 && HM.rxq.size() == 0; i++)
         @(posedge pclk);
      chk("host_rxd", e, HM.rxq.size() ? HM.rxq.pop_front() : 9'h1ff);
   endtask
   function automatic int line_of(input int c);
      return (hn && ln) ? c : c & 32'hff;
   endfunction
   task automatic host_data(input logic [8:0] c);
      exp_line.push_back(line_of(c));
      HM.send(c);
   endtask
   task automatic plus3(input int pre);
      repeat (pre) @(posedge pclk);
      repeat (3) host_data(MHS_ESC_RST);
      repeat (60) @(posedge pclk);
   endtask
   task automatic give_verdict();
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // model compare and far-side stimulus
   // ------------------------------------------------------------
   always @(posedge pclk)
   begin
      line_tx_ready <= 1'($random(seed));
      if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1)
         chk("line_tx", exp_line.size() ? exp_line.pop_front() : -1, line_tx_data);
      if (cmd_valid === 1'b1)
         chk("cmd_data", exp_cmd.size() ? exp_cmd.pop_front() : -1, cmd_data);
   end
   initial
   begin
      repeat (90000) @(posedge pclk);
      errors++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      int c;
      logic [31:0] r;
      logic e;
      {presetn, psel, penable, pwrite, escape_capable_pin, line_rx_valid} = '0;
      {paddr, pwdata, line_rx_data, line_tx_ready} = '0;
      line_carrier = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      HM.rxq.delete();
      rd(MHS_OFF_SERFMT, 32'h2);
      rd(MHS_OFF_ESCCHR, 32'h2b);
      rd(MHS_OFF_STATUS, 32'h82);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("pslverr", 1'b1, e);
      for (int k = 0; k < 8; k++)
      begin
         wr(MHS_OFF_SERFMT, k);
         HM.bc = CLK_HZ / MHS_RATES[k];
         c = $random(seed) & 32'h7f;
         exp_cmd.push_back(c);
         HM.send(9'(c));
      end
      wr(MHS_OFF_SERFMT, 32'h6);
      HM.bc = CLK_HZ / MHS_RATES[6];
      wr(MHS_OFF_GUARD, 32'h2);
      for (int k = 0; k < 4; k++)
      begin
         wr(MHS_OFF_CTRL, 32'h1 | k << 1);
         get_rx(k == 1 ? MHS_CHR_D : k == 2 ? MHS_CHR_V : MHS_CHR_C);
         mode_is(1'b1);
         // top bit forced so payload never matches the escape character
         host_data(9'($random(seed) & 32'hff | 32'h80));
         c = $random(seed) & 32'hff;
         line_rx_data <= 9'(c);
         line_rx_valid <= 1'b1;
         do @(negedge pclk); while (line_rx_ready !== 1'b1);
         @(posedge pclk);
         line_rx_valid <= 1'b0;
         get_rx(9'(c));
         if (k == 0)
         begin
            wr(MHS_OFF_PINFN, 32'h30);
            escape_capable_pin <= 1'b1;
            mode_is(1'b0);
            escape_capable_pin <= 1'b0;
         end
         else if (k == 1)
         begin
            wr(MHS_OFF_SERFMT, 32'he);
            HM.nb = 9;
            hn = 1;
            wr(MHS_OFF_LINE, 32'h1);
            wr(MHS_OFF_PROTO, 32'h1);
            host_data(9'h1a5);
            mode_is(1'b1);
            wr(MHS_OFF_PROTO, 32'h0);
            HM.send(9'h1c3);
            mode_is(1'b0);
            wr(MHS_OFF_SERFMT, 32'h6);
            HM.nb = 8;
            hn = 0;
            wr(MHS_OFF_LINE, 32'h2);
            ln = 1;
         end
         else if (k == 2)
         begin
            wr(MHS_OFF_GUARD, 32'hff);
            plus3(40);
            mode_is(1'b1);
            wr(MHS_OFF_GUARD, 32'h2);
            plus3(40);
            mode_is(1'b0);
         end
         else
         begin
            wr(MHS_OFF_GUARD, 32'h0);
            plus3(0);
            mode_is(1'b0);
            wr(MHS_OFF_CTRL, 32'h8);
            mode_is(1'b1);
            line_carrier <= 1'b0;
            mode_is(1'b0);
            get_rx(MHS_CHR_N);
            line_carrier <= 1'b1;
         end
      end
      repeat (50) @(posedge pclk);
      chk("queues empty", 0, exp_line.size() + exp_cmd.size());
      give_verdict();
   end
endmodule
`default_nettype wire
